// >>> common/adc_seq_pkg.sv
/*
 * constants, register map and carrier types for the converter channel sequencer.
 * assumes an APB slave with 32-bit data; each register is one aligned word.
 */
// Notes on behaviour
// - range register: low nibble first, high last
// - any range write loads current channel low
// - current channel advances after each conversion
// - after high channel, current wraps to low
// - equal low and high repeats one channel
// - two-bit gain code selects input range
// - range or gain write starts settle timer
// - settling flag reads one while timer runs
// - data port write triggers only if irq disabled
// - irq enabled: only timer or external trigger
// - stay busy until converter signals completion
// - busy flag bit seven while converting
// - result pushed low byte then high byte
// - each data byte read pops the fifo
// - results are raw signed sixteen-bit values
// - same encoding kept in unipolar polarity
// - scan converts current channel up to high, busy throughout; a drop ends it
// - scan adds channel count to fifo count
// - scan enable picks run from current channel up to high, or single
// - irq enabled: source select picks trigger
// - fifo holds 48 samples; overflow drops new
package adc_seq_pkg;

    // ==========================================================
    // register map: each register has an index, its byte address is four times it
    localparam int IDX_DATA_LOW = 0;
    localparam int IDX_DATA_HIGH = 1;
    localparam int IDX_CHANNEL_RANGE = 2;
    localparam int IDX_GAIN_STATUS = 3;
    localparam int IDX_CONTROL = 4;
    localparam int IDX_FIFO_STATUS = 5;
    localparam logic [7:0] ADDR_DATA_LOW = 8'(4 * IDX_DATA_LOW);
    localparam logic [7:0] ADDR_DATA_HIGH = 8'(4 * IDX_DATA_HIGH);
    localparam logic [7:0] ADDR_CHANNEL_RANGE = 8'(4 * IDX_CHANNEL_RANGE);
    localparam logic [7:0] ADDR_GAIN_STATUS = 8'(4 * IDX_GAIN_STATUS);
    localparam logic [7:0] ADDR_CONTROL = 8'(4 * IDX_CONTROL);
    localparam logic [7:0] ADDR_FIFO_STATUS = 8'(4 * IDX_FIFO_STATUS);

    // ==========================================================
    // field positions
    localparam int GAIN_LSB = 0;
    localparam int SCAN_BIT = 2;
    localparam int SETTLE_BIT = 5;
    localparam int BUSY_BIT = 7;
    localparam int IRQ_EN_BIT = 0;
    localparam int SRC_SEL_BIT = 4;
    localparam int FIFO_RESET_BIT = 7;
    localparam int OVF_BIT = 15;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SETTLE_NS = 10_000;
    localparam int CONV_MAX_NS = 5_000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONV_TIMEOUT_CYCLES = (CONV_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;

    localparam int FIFO_SAMPLES = 48;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10,
        ST_STORE_HIGH = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic [3:0] high;
        logic [3:0] low;
    } chan_range_t;

    typedef struct packed {
        logic start;
        logic [3:0] channel;
        logic [1:0] gain;
    } conv_req_t;

endpackage

// >>> rtl/adc_channel_sequencer.sv
/*
 * register front end, trigger gating, channel sequencer, settle timer and
 * byte fifo around an external 16-bit converter.
 * assumes the converter answers conv_done (one-cycle pulse, same clock)
 * with conv_data; external and timer triggers arrive as asynchronous pins.
 */
`timescale 1ns/1ps
module adc_channel_sequencer #(
    parameter int FIFO_SAMPLES = adc_seq_pkg::FIFO_SAMPLES,
    parameter int SETTLE_CYCLES = adc_seq_pkg::SETTLE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output adc_seq_pkg::conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    input wire logic ext_trigger,
    input wire logic timer_trigger
);
    localparam int DEPTH = 2 * FIFO_SAMPLES;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);

    // ==========================================================
    // apb decode
    wire logic setup = psel && !penable;
    // writes land at the access edge, when pready completes the transfer
    wire logic access = psel && penable && pready;
    wire logic wr = access && pwrite;
    wire logic rd = setup && !pwrite;
    wire logic hit_low = paddr == adc_seq_pkg::ADDR_DATA_LOW;
    wire logic hit_high = paddr == adc_seq_pkg::ADDR_DATA_HIGH;
    wire logic hit_range = paddr == adc_seq_pkg::ADDR_CHANNEL_RANGE;
    wire logic hit_gain = paddr == adc_seq_pkg::ADDR_GAIN_STATUS;
    wire logic hit_ctrl = paddr == adc_seq_pkg::ADDR_CONTROL;
    wire logic hit_fstat = paddr == adc_seq_pkg::ADDR_FIFO_STATUS;
    wire logic mapped = hit_low | hit_high | hit_range | hit_gain | hit_ctrl | hit_fstat;

    // ==========================================================
    // registers
    adc_seq_pkg::chan_range_t chan_range;
    logic [3:0] cur_chan;
    logic [1:0] gain_code;
    logic scan_mode_enable;
    logic adc_irq_enable;
    logic trigger_source_select;
    logic [SW-1:0] settle_cnt;
    logic conversion_busy_flag;
    logic fifo_overflow_flag;

    // ==========================================================
    // trigger pins: three stages, rising edge when second and third agree high on a change
    logic [2:0] ext_sync;
    logic [2:0] tmr_sync;
    logic ext_seen;
    logic tmr_seen;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_sync <= 3'h0;
            tmr_sync <= 3'h0;
            ext_seen <= 1'b0;
            tmr_seen <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_trigger};
            tmr_sync <= {tmr_sync[1:0], timer_trigger};
            if (ext_sync[1] == ext_sync[2]) begin
                ext_seen <= ext_sync[2];
            end
            if (tmr_sync[1] == tmr_sync[2]) begin
                tmr_seen <= tmr_sync[2];
            end
        end
    end
    wire logic ext_rise = ext_sync[1] && ext_sync[2] && !ext_seen;
    wire logic tmr_rise = tmr_sync[1] && tmr_sync[2] && !tmr_seen;

    wire logic sw_trigger = wr && hit_low && !adc_irq_enable;
    wire logic hw_trigger = adc_irq_enable
        && (trigger_source_select ? ext_rise : tmr_rise);
    // a trigger during a running conversion or scan is dropped
    wire logic trigger = (sw_trigger || hw_trigger) && !conversion_busy_flag;

    // ==========================================================
    // fifo of bytes
    logic [7:0] fifo_mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] byte_count;
    logic [7:0] high_hold;
    adc_seq_pkg::seq_state_t state;

    wire logic pop = rd && (hit_low || hit_high) && byte_count != '0;
    wire logic fifo_reset = wr && hit_high && pwdata[adc_seq_pkg::FIFO_RESET_BIT];
    // room for a whole sample is checked once, so a full fifo never splits a sample
    wire logic room = byte_count <= CW'(DEPTH - 2);
    wire logic done_ok = state == adc_seq_pkg::ST_WAIT && conv_done;
    wire logic push_low = done_ok && room;
    wire logic push_high = state == adc_seq_pkg::ST_STORE_HIGH;
    wire logic push = push_low || push_high;
    wire logic [7:0] push_byte = push_high ? high_hold : conv_data[7:0];
    wire logic [PW-1:0] wr_next = wr_ptr == PW'(DEPTH - 1) ? '0 : wr_ptr + 1'b1;
    wire logic [PW-1:0] rd_next = rd_ptr == PW'(DEPTH - 1) ? '0 : rd_ptr + 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_mem
            always_ff @(posedge core_clk) begin
                if (push && wr_ptr == PW'(gi)) begin
                    fifo_mem[gi] <= push_byte;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            byte_count <= '0;
            high_hold <= 8'h00;
            fifo_overflow_flag <= 1'b0;
        end else if (fifo_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            byte_count <= '0;
            // a drop in the clearing cycle still sets the flag
            fifo_overflow_flag <= done_ok && !room;
        end else begin
            if (push) begin
                wr_ptr <= wr_next;
            end
            if (pop) begin
                rd_ptr <= rd_next;
            end
            if (push && !pop) begin
                byte_count <= byte_count + 1'b1;
            end else if (pop && !push) begin
                byte_count <= byte_count - 1'b1;
            end
            if (done_ok) begin
                high_hold <= conv_data[15:8];
            end
            if (done_ok && !room) begin
                fifo_overflow_flag <= 1'b1;
            end
        end
    end

    // ==========================================================
    // sequencer
    logic scan_active;
    wire logic at_high = cur_chan == chan_range.high;
    wire logic [3:0] chan_after = at_high ? chan_range.low : cur_chan + 1'b1;
    wire logic range_wr = wr && hit_range;
    wire logic gain_wr = wr && hit_gain;
    wire logic finished = done_ok;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= adc_seq_pkg::ST_IDLE;
            conversion_busy_flag <= 1'b0;
            scan_active <= 1'b0;
            cur_chan <= 4'h0;
            conv_req <= '0;
        end else begin
            conv_req.start <= 1'b0;
            if (range_wr) begin
                cur_chan <= pwdata[3:0];
            end
            case (state)
                adc_seq_pkg::ST_IDLE: begin
                    if (trigger) begin
                        conversion_busy_flag <= 1'b1;
                        scan_active <= scan_mode_enable;
                        state <= adc_seq_pkg::ST_START;
                    end
                end
                adc_seq_pkg::ST_START: begin
                    conv_req.start <= 1'b1;
                    conv_req.channel <= cur_chan;
                    conv_req.gain <= gain_code;
                    state <= adc_seq_pkg::ST_WAIT;
                end
                adc_seq_pkg::ST_WAIT: begin
                    // busy holds until the converter reports done; a slow part is not aborted
                    if (finished) begin
                        if (!range_wr) begin
                            cur_chan <= chan_after;
                        end
                        state <= room ? adc_seq_pkg::ST_STORE_HIGH
                            : adc_seq_pkg::ST_IDLE;
                        if (!room) begin
                            conversion_busy_flag <= 1'b0;
                            scan_active <= 1'b0;
                        end
                    end
                end
                adc_seq_pkg::ST_STORE_HIGH: begin
                    if (scan_active && cur_chan != chan_range.low) begin
                        state <= adc_seq_pkg::ST_START;
                    end else begin
                        state <= adc_seq_pkg::ST_IDLE;
                        conversion_busy_flag <= 1'b0;
                        scan_active <= 1'b0;
                    end
                end
                default: begin
                    state <= adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // configuration registers and settle timer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan_range <= '0;
            gain_code <= 2'h0;
            scan_mode_enable <= 1'b0;
            adc_irq_enable <= 1'b0;
            trigger_source_select <= 1'b0;
            settle_cnt <= '0;
        end else begin
            if (range_wr) begin
                chan_range <= pwdata[7:0];
            end
            if (gain_wr) begin
                gain_code <= pwdata[adc_seq_pkg::GAIN_LSB +: 2];
                scan_mode_enable <= pwdata[adc_seq_pkg::SCAN_BIT];
            end
            if (wr && hit_ctrl) begin
                adc_irq_enable <= pwdata[adc_seq_pkg::IRQ_EN_BIT];
                trigger_source_select <= pwdata[adc_seq_pkg::SRC_SEL_BIT];
            end
            if (range_wr || gain_wr) begin
                settle_cnt <= SW'(SETTLE_CYCLES);
            end else if (settle_cnt != '0) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end

    // ==========================================================
    // read mux; answers in the access cycle, zero wait states
    wire logic [7:0] gain_status = {conversion_busy_flag, 1'b0,
        settle_cnt != '0, 2'b00, scan_mode_enable, gain_code};
    wire logic [7:0] ctrl_read = {3'b000, trigger_source_select, 3'b000, adc_irq_enable};
    wire logic [31:0] fifo_status = {16'h0000, fifo_overflow_flag, 7'h00,
        8'(byte_count >> 1)};
    wire logic [7:0] head = fifo_mem[rd_ptr];
    wire logic [31:0] rd_word = hit_low || hit_high ? {24'h000000, head}
        : hit_range ? {24'h000000, chan_range}
        : hit_gain ? {24'h000000, gain_status}
        : hit_ctrl ? {24'h000000, ctrl_read}
        : hit_fstat ? fifo_status : 32'h00000000;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= rd ? rd_word : 32'h00000000;
            end
        end
    end
endmodule

// >>> verification/adc_conv_model.sv
/*
 * behavioural stand-in for the 16-bit converter behind the sequencer.
 * assumes one clock shared with the sequencer; the bench sets latency and top byte.
 */
`timescale 1ns/1ps
module adc_conv_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire adc_seq_pkg::conv_req_t conv_req,
    input wire logic [7:0] lat,
    input wire logic [7:0] top,
    output logic conv_done,
    output logic [15:0] conv_data
);
    logic [7:0] cnt;
    logic [3:0] ch;
    logic run;
    // ========
    // conversion timing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_done <= 1'b0;
            conv_data <= 16'h0;
            cnt <= 8'h0;
            ch <= 4'h0;
            run <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            // data only means something beside the done pulse
            conv_data <= ~conv_data;
            if (conv_req.start) begin
                run <= 1'b1;
                cnt <= lat;
                ch <= conv_req.channel;
            end else if (run && cnt == 8'h0) begin
                run <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= {top, 4'h5, ch};
            end else if (run) begin
                cnt <= cnt - 8'h1;
            end
        end
    end
endmodule

// >>> verification/adc_seq_monitor.sv
/*
 * checker for the channel sequencer: bus answers, trigger gating, channel order.
 * assumes it is bound to the sequencer top and sees only its ports.
 */
`timescale 1ns/1ps
module adc_seq_monitor #(
    parameter int FIFO_SAMPLES = 48,
    parameter int SETTLE_CYCLES = 100
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire adc_seq_pkg::conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    input wire logic ext_trigger,
    input wire logic timer_trigger
);
    // ========
    // reference state
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] cur;
    logic [1:0] gain;
    logic irq;
    logic pend;
    logic [2:0] quiet;
    int settle;
    wire setup = psel && !penable;
    // writes land when the access phase completes
    wire wset = psel && penable && pready && pwrite;
    wire rset = setup && !pwrite;
    wire bad_addr = (paddr[1:0] != 2'h0) || (paddr > 8'h14);
    wire range_wr = wset && paddr == 8'h08;
    wire gain_wr = wset && paddr == 8'h0C;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hi <= 4'h0;
            lo <= 4'h0;
            cur <= 4'h0;
            gain <= 2'h0;
            irq <= 1'b0;
            pend <= 1'b0;
            quiet <= 3'h7;
            settle <= 0;
        end else begin
            pend <= conv_req.start || (pend && !conv_done);
            quiet <= conv_done ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
            settle <= (range_wr || gain_wr) ? SETTLE_CYCLES : (settle > 0 ? settle - 1 : 0);
            gain <= gain_wr ? pwdata[1:0] : gain;
            irq <= (wset && paddr == 8'h10) ? pwdata[0] : irq;
            if (range_wr) begin
                hi <= pwdata[7:4];
                lo <= pwdata[3:0];
                cur <= pwdata[3:0];
            end else if (conv_done && pend) begin
                cur <= (cur == hi) ? lo : cur + 4'h1;
            end
        end
    end
    // ========
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_setup_answered: assert property (setup |=> pready)
        else $error("no answer in the access cycle");
    a_err_unmapped: assert property (setup && bad_addr |=> pslverr && pready)
        else $error("unmapped access not refused");
    a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start longer than one cycle");
    a_start_idle: assert property (conv_req.start |-> !pend)
        else $error("start while converting");
    a_channel_order: assert property (conv_req.start |-> conv_req.channel == cur)
        else $error("wrong conversion channel");
    a_gain_forwarded: assert property (conv_req.start |-> conv_req.gain == gain)
        else $error("wrong gain code");
    a_soft_trigger: assert property (wset && paddr == 8'h00 && !irq && !pend
        && quiet >= 3'h3 |-> ##2 conv_req.start)
        else $error("data write did not start");
    a_irq_blocks: assert property (wset && paddr == 8'h00 && irq |=> !conv_req.start [*3])
        else $error("data write started with irq enabled");
    a_settle_flag: assert property (rset && paddr == 8'h0C && settle > 2 |=> prdata[5])
        else $error("settle flag low while settling");
    a_fifo_bound: assert property (rset && paddr == 8'h14 |=> prdata[7:0] <= FIFO_SAMPLES)
        else $error("sample count above depth");
endmodule

bind adc_channel_sequencer adc_seq_monitor #(
    .FIFO_SAMPLES(FIFO_SAMPLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) mon (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
    .ext_trigger(ext_trigger), .timer_trigger(timer_trigger)
);

// >>> verification/testbench.sv
/*
 * self-checking bench for the channel sequencer over apb.
 * assumes the converter model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, conv_done, err;
    logic ext_trigger, timer_trigger;
    logic [7:0] paddr, lat, top;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] conv_data;
    adc_seq_pkg::conv_req_t conv_req;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;

    adc_channel_sequencer #(.SETTLE_CYCLES(5)) dut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
        .ext_trigger(ext_trigger), .timer_trigger(timer_trigger));
    adc_conv_model conv (.core_clk(core_clk), .rst(rst), .conv_req(conv_req), .lat(lat),
        .top(top), .conv_done(conv_done), .conv_data(conv_data));

    // ========
    // tasks
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // polls a status bit with a bounded count, as software would
    task automatic wait_clear(input int b);
        int n = 0;
        do begin
            apb(1'b0, 8'h0C, 32'h0);
            n++;
        end while (r[b] === 1'b1 && n < 300);
        chk(r[b], 32'h0);
    endtask
    task automatic sample(input logic [3:0] ch);
        rd_chk(8'h00, {24'h0, 4'h5, ch});
        rd_chk(8'h04, {24'h0, top});
    endtask
    task automatic pin(input logic ext);
        ext_trigger <= ext;
        timer_trigger <= !ext;
        repeat (6) @(posedge core_clk);
        ext_trigger <= 1'b0;
        timer_trigger <= 1'b0;
        @(posedge core_clk);
        wait_clear(7);
    endtask

    // ========
    // clock, timeout, tests
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, ext_trigger, timer_trigger} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        lat = 8'h14;
        top = 8'h12;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h18, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 8'h08, 32'h20);
        rd_chk(8'h0C, 32'h20);
        wait_clear(5);
        rd_chk(8'h08, 32'h20);
        apb(1'b1, 8'h0C, 32'h01);
        wait_clear(5);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, 32'h80);
            rd_chk(8'h0C, 32'h81);
            apb(1'b1, 8'h00, 32'h80);
            wait_clear(7);
            rd_chk(8'h14, 32'h1);
            sample(4'(i % 3));
        end
        rd_chk(8'h14, 32'h0);
        apb(1'b1, 8'h10, 32'h01);
        apb(1'b1, 8'h00, 32'h80);
        rd_chk(8'h0C, 32'h01);
        apb(1'b1, 8'h10, 32'h11);
        pin(1'b1);
        sample(4'h1);
        apb(1'b1, 8'h10, 32'h01);
        pin(1'b0);
        sample(4'h2);
        apb(1'b1, 8'h10, 32'h00);
        top <= 8'h80;
        apb(1'b1, 8'h08, 32'h44);
        wait_clear(5);
        repeat (2) begin
            apb(1'b1, 8'h00, 32'h80);
            wait_clear(7);
            sample(4'h4);
        end
        lat <= 8'h0;
        apb(1'b1, 8'h08, 32'h31);
        apb(1'b1, 8'h0C, 32'h07);
        wait_clear(5);
        apb(1'b1, 8'h00, 32'h80);
        wait_clear(7);
        rd_chk(8'h14, 32'h3);
        for (int c = 1; c < 4; c++) sample(4'(c));
        apb(1'b1, 8'h08, 32'hF0);
        wait_clear(5);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h00, 32'h80);
            wait_clear(7);
        end
        rd_chk(8'h14, 32'h8030);
        sample(4'h0);
        apb(1'b1, 8'h04, 32'h80);
        rd_chk(8'h14, 32'h0);
        conclude();
    end
endmodule
